// ==== logic/usc_defines.svh ====
// Constants of the serial port control block: bit positions, reset value, timing.
// Assumes inclusion by bare name from the design files only.
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH

`define USC_CTRL_RESET    8'h40
`define USC_BIT_MODE      7
`define USC_BIT_UNUSED    6
`define USC_BIT_MCE       5
`define USC_BIT_REN       4
`define USC_BIT_TB8       3
`define USC_BIT_RB8       2
`define USC_BIT_TI        1
`define USC_BIT_RI        0
`define USC_BIT_CYCLES    16
`define USC_CNT_W         16

`endif

// ==== logic/usc_pkg.sv ====
// Types of the serial port control block.
// Assumes nothing of its surroundings.
package usc_pkg;

  typedef enum logic [2:0] {
    USC_IDLE,
    USC_START,
    USC_DATA,
    USC_NINTH,
    USC_STOP
  } usc_state_t;

endpackage

// ==== logic/usc_receiver.sv ====
// Receive shifter: start detection, mid-bit sampling and frame completion pulse.
// Assumes a pin that is already synchronous to clock_i.
`timescale 1ns/10ps
`include "usc_defines.svh"

module usc_receiver #(
  parameter int                BIT_CYCLES = `USC_BIT_CYCLES,
  parameter int                CNT_W      = `USC_CNT_W
) (
  input  wire logic            clock_i,   // System clock.
  input  wire logic            nrst_i,    // Asynchronous reset, active low.
  input  wire logic            enable_i,  // Receiver enable bit.
  input  wire logic            mode9_i,   // Frame length select: 1 for 9-bit frames.
  input  wire logic            rx_i,      // Serial receive pin.
  output logic                 done_o,    // One-cycle pulse at the stop bit sample.
  output logic [7:0]           data_o,    // Received byte.
  output logic                 ninth_o    // Stop bit in 8-bit mode, ninth bit in 9-bit mode.
);

  localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYCLES / 2 - 1);

  usc_pkg::usc_state_t state;
  usc_pkg::usc_state_t next_state;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    next_cnt;
  logic [2:0]          idx;
  logic [2:0]          next_idx;
  logic [7:0]          next_data;
  logic                next_ninth;
  logic                next_done;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_idx   = idx;
    next_data  = data_o;
    next_ninth = ninth_o;
    next_done  = 1'b0;
    if (!enable_i) begin
      next_state = usc_pkg::USC_IDLE;
    end else if (state == usc_pkg::USC_IDLE) begin
      if (!rx_i) begin
        next_state = usc_pkg::USC_START;
        next_cnt   = HALF_LAST;
      end
    end else if (cnt != '0) begin
      next_cnt = cnt - CNT_W'(1);
    end else begin
      next_cnt = BIT_LAST;
      unique case (state)
        usc_pkg::USC_START: begin
          // A start bit that is high again at mid-bit was a glitch.
          next_state = rx_i ? usc_pkg::USC_IDLE : usc_pkg::USC_DATA;
          next_idx   = 3'd0;
        end
        usc_pkg::USC_DATA: begin
          next_data = {rx_i, data_o[7:1]};
          next_idx  = idx + 3'd1;
          if (idx == 3'd7) begin
            next_state = mode9_i ? usc_pkg::USC_NINTH : usc_pkg::USC_STOP;
          end
        end
        usc_pkg::USC_NINTH: begin
          next_ninth = rx_i;
          next_state = usc_pkg::USC_STOP;
        end
        usc_pkg::USC_STOP: begin
          if (!mode9_i) begin
            next_ninth = rx_i;
          end
          next_done  = 1'b1;
          next_state = usc_pkg::USC_IDLE;
        end
        usc_pkg::USC_IDLE: begin
          next_state = usc_pkg::USC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state   <= usc_pkg::USC_IDLE;
      cnt     <= '0;
      idx     <= 3'd0;
      data_o  <= 8'h00;
      ninth_o <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      idx     <= next_idx;
      data_o  <= next_data;
      ninth_o <= next_ninth;
      done_o  <= next_done;
    end
  end

endmodule

// ==== logic/usc_serial_port.sv ====
// Serial port control register with transmitter and receive buffer.
// Assumes strobes and data from the CPU special-function-register space, synchronous to clock_i.
// Function
// - Bit six of the control register reads one; writes to it are ignored.
// - Setting the transmit-done flag requests interrupt service while the interrupt is enabled.
// - Transmit-done flag is never cleared by hardware; only software clears it.
// - Receive-done flag requests interrupt when enabled and stays until software clears it.
// - 8-bit frame: start, eight data LSB first, stop; stop goes to ninth receive bit.
// - 9-bit frame adds ninth transmit bit; received ninth bit stored, stop ignored.
// - Load byte and set receive-done only if flag clear and filter condition holds.
// - Writing the data buffer while the transmitter is idle starts shifting out a new frame at once; writes during a frame are ignored.
`timescale 1ns/10ps
`include "usc_defines.svh"

module usc_serial_port #(
  parameter int                BIT_CYCLES = `USC_BIT_CYCLES,
  parameter int                CNT_W      = `USC_CNT_W
) (
  input  wire logic            clock_i,         // System clock, 250 MHz.
  input  wire logic            nrst_i,          // Asynchronous reset, active low.
  input  wire logic            ctrl_wr_i,       // Write strobe of the control register.
  input  wire logic            data_wr_i,       // Write strobe of the data buffer register.
  input  wire logic [7:0]      wdata_i,         // Write data for either register.
  input  wire logic            irq_enable_i,    // Serial port interrupt enable.
  input  wire logic            serial_receive_pin_i,  // Receive line.
  output logic [7:0]           serial_port_control_o, // Control register contents.
  output logic [7:0]           serial_data_buffer_o,  // Receive buffer contents.
  output logic                 serial_transmit_pin_o, // Transmit line.
  output logic                 irq_o            // Interrupt request, level.
);

  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);

  // A finished frame is kept only if nothing unread is pending and the address filter passes it.
  function automatic logic frame_kept(
    input logic pending,   // Receive-done flag already set.
    input logic filter_on, // Multiprocessor filter enabled.
    input logic ninth      // Stop bit in 8-bit frames, ninth bit in 9-bit frames.
  );
    return !pending && (!filter_on || ninth);
  endfunction

  // Interrupt request level for an enable and a control register value.
  // It is fed the flags of the coming edge, so the request rises together with a new flag.
  function automatic logic irq_wanted(
    input logic       enable, // Outside interrupt enable.
    input logic [7:0] regval  // Control register value.
  );
    return enable && (regval[`USC_BIT_TI] || regval[`USC_BIT_RI]);
  endfunction

  // Next value of the transmit bit timer: counts down, then reloads for the next bit.
  function automatic logic [CNT_W-1:0] bit_timer_next(
    input logic [CNT_W-1:0] now // Current count.
  );
    return (now == '0) ? BIT_LAST : now - CNT_W'(1);
  endfunction

  // Control register after this cycle's CPU write and hardware events; sets are applied last.
  function automatic logic [7:0] ctrl_update(
    input logic [7:0] now,     // Current contents.
    input logic       write,   // CPU write strobe.
    input logic [7:0] wdata,   // CPU write data.
    input logic       tx_done, // Transmitter entered its stop bit.
    input logic       rx_take, // Receiver frame accepted.
    input logic       rx_bit   // Stop or ninth bit of that frame.
  );
    logic [7:0] result;
    result = write ? wdata : now;
    result[`USC_BIT_UNUSED] = 1'b1;
    if (tx_done) begin
      result[`USC_BIT_TI] = 1'b1;
    end
    if (rx_take) begin
      result[`USC_BIT_RI]  = 1'b1;
      result[`USC_BIT_RB8] = rx_bit;
    end
    return result;
  endfunction

  logic [7:0]          ctrl;
  logic [7:0]          next_ctrl;
  logic [7:0]          next_rbuf;
  logic                next_irq;
  usc_pkg::usc_state_t tx_state;
  usc_pkg::usc_state_t next_tx_state;
  logic [CNT_W-1:0]    tx_cnt;
  logic [CNT_W-1:0]    next_tx_cnt;
  logic [7:0]          tx_shift;
  logic [7:0]          next_tx_shift;
  logic [2:0]          tx_idx;
  logic [2:0]          next_tx_idx;
  logic                next_tx_pin;
  logic                ti_set;
  logic                rx_done;
  logic [7:0]          rx_data;
  logic                rx_ninth;
  logic                rx_load;

  // Receive shifter; it is held idle while the receive enable bit is clear.
  usc_receiver #(
    .BIT_CYCLES (BIT_CYCLES),
    .CNT_W      (CNT_W)
  ) u_receiver (
    .clock_i  (clock_i),
    .nrst_i   (nrst_i),
    .enable_i (ctrl[`USC_BIT_REN]),
    .mode9_i  (ctrl[`USC_BIT_MODE]),
    .rx_i     (serial_receive_pin_i),
    .done_o   (rx_done),
    .data_o   (rx_data),
    .ninth_o  (rx_ninth)
  );

  // The receiver's done pulse lasts one cycle, so each frame is judged exactly once.
  assign rx_load = rx_done
                   && frame_kept(ctrl[`USC_BIT_RI], ctrl[`USC_BIT_MCE], rx_ninth);

  // Control register; hardware sets win over a software clear in the same cycle.
  always_comb begin
    next_ctrl = ctrl_update(ctrl, ctrl_wr_i, wdata_i, ti_set, rx_load, rx_ninth);
    next_rbuf = serial_data_buffer_o;
    if (rx_load) begin
      next_rbuf = rx_data;
    end
    next_irq = irq_wanted(irq_enable_i, next_ctrl);
  end

  // The receive buffer keeps the last accepted byte; a discarded frame leaves it untouched.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl                 <= `USC_CTRL_RESET;
      serial_data_buffer_o <= 8'h00;
      irq_o                <= 1'b0;
    end else begin
      ctrl                 <= next_ctrl;
      serial_data_buffer_o <= next_rbuf;
      irq_o                <= next_irq;
    end
  end

  assign serial_port_control_o = ctrl;

  // Transmitter. A data write while a frame is in flight is ignored.
  // Frame length and the ninth transmit bit are read live, so software must not change them mid-frame.
  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt   = tx_cnt;
    next_tx_shift = tx_shift;
    next_tx_idx   = tx_idx;
    next_tx_pin   = serial_transmit_pin_o;
    ti_set        = 1'b0;
    if (tx_state == usc_pkg::USC_IDLE) begin
      next_tx_pin = 1'b1;
      if (data_wr_i) begin
        next_tx_state = usc_pkg::USC_START;
        next_tx_shift = wdata_i;
        next_tx_cnt   = BIT_LAST;
        next_tx_idx   = 3'd0;
        next_tx_pin   = 1'b0;
      end
    end else if (tx_cnt != '0) begin
      next_tx_cnt = bit_timer_next(tx_cnt);
    end else begin
      next_tx_cnt = bit_timer_next(tx_cnt);
      unique case (tx_state)
        usc_pkg::USC_START: begin
          next_tx_state = usc_pkg::USC_DATA;
          next_tx_pin   = tx_shift[0];
        end
        usc_pkg::USC_DATA: begin
          next_tx_idx   = tx_idx + 3'd1;
          next_tx_shift = {1'b0, tx_shift[7:1]};
          if (tx_idx == 3'd7) begin
            if (ctrl[`USC_BIT_MODE]) begin
              next_tx_state = usc_pkg::USC_NINTH;
              next_tx_pin   = ctrl[`USC_BIT_TB8];
            end else begin
              next_tx_state = usc_pkg::USC_STOP;
              next_tx_pin   = 1'b1;
              ti_set        = 1'b1;
            end
          end else begin
            next_tx_pin = tx_shift[1];
          end
        end
        usc_pkg::USC_NINTH: begin
          next_tx_state = usc_pkg::USC_STOP;
          next_tx_pin   = 1'b1;
          ti_set        = 1'b1;
        end
        usc_pkg::USC_STOP: begin
          next_tx_state = usc_pkg::USC_IDLE;
          next_tx_pin   = 1'b1;
        end
        usc_pkg::USC_IDLE: begin
          next_tx_state = usc_pkg::USC_IDLE;
        end
      endcase
    end
  end

  // The transmit line idles high from reset on.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state              <= usc_pkg::USC_IDLE;
      tx_cnt                <= '0;
      tx_shift              <= 8'h00;
      tx_idx                <= 3'd0;
      serial_transmit_pin_o <= 1'b1;
    end else begin
      tx_state              <= next_tx_state;
      tx_cnt                <= next_tx_cnt;
      tx_shift              <= next_tx_shift;
      tx_idx                <= next_tx_idx;
      serial_transmit_pin_o <= next_tx_pin;
    end
  end

endmodule

// ==== tb/usc_props.sv ====
// Port checker of the serial port control block.
// Assumes it is bound onto usc_serial_port and shares its clock and reset.
`timescale 1ns/10ps
module usc_props #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic       clock_i,               // Clock.
  input wire logic       nrst_i,                // Reset, active low.
  input wire logic       ctrl_wr_i,             // Control write.
  input wire logic       data_wr_i,             // Data write.
  input wire logic [7:0] wdata_i,               // Write data.
  input wire logic       irq_enable_i,          // Interrupt enable.
  input wire logic       serial_receive_pin_i,  // Receive line.
  input wire logic [7:0] serial_port_control_o, // Control register.
  input wire logic [7:0] serial_data_buffer_o,  // Receive buffer.
  input wire logic       serial_transmit_pin_o, // Transmit line.
  input wire logic       irq_o                  // Interrupt request.
);
  localparam int IDLE = 10 * BIT_CYCLES;
  logic [7:0] hi_cnt;
  logic [7:0] next_hi_cnt;
  // Counts high line cycles; a long high run proves the transmitter is idle.
  always_comb begin
    next_hi_cnt = 8'h00;
    if (serial_transmit_pin_o) next_hi_cnt = (hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01;
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) hi_cnt <= 8'h00;
    else hi_cnt <= next_hi_cnt;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  fixed_one_a: assert property (serial_port_control_o[6])
    else $error("bit six reads zero");
  ctrl_write_a: assert property (ctrl_wr_i |=> serial_port_control_o[7:3] == ($past(wdata_i[7:3]) | 5'h08))
    else $error("control write lost");
  irq_level_a: assert property (irq_o == ($past(irq_enable_i) && (serial_port_control_o[1] || serial_port_control_o[0])))
    else $error("interrupt request wrong");
  ti_hold_a: assert property (serial_port_control_o[1] && !ctrl_wr_i |=> serial_port_control_o[1])
    else $error("transmit flag dropped");
  ri_hold_a: assert property (serial_port_control_o[0] && !ctrl_wr_i |=> serial_port_control_o[0])
    else $error("receive flag dropped");
  rx_off_a: assert property ((!serial_port_control_o[4])[*3] ##0 !ctrl_wr_i |=> !$rose(serial_port_control_o[0]))
    else $error("frame taken while disabled");
  ti_stop_a: assert property ($rose(serial_port_control_o[1]) && !$past(ctrl_wr_i) |-> serial_transmit_pin_o)
    else $error("transmit flag not at stop bit");
  buf_load_a: assert property ($changed(serial_data_buffer_o) |-> $rose(serial_port_control_o[0]))
    else $error("buffer loaded without flag");
  tx_start_a: assert property (data_wr_i && int'(hi_cnt) > IDLE |=> !serial_transmit_pin_o)
    else $error("no start bit after write");
  tx_cause_a: assert property ($fell(serial_transmit_pin_o) && int'($past(hi_cnt)) > IDLE |-> $past(data_wr_i))
    else $error("frame without write");
endmodule
bind usc_serial_port usc_props #(.BIT_CYCLES(BIT_CYCLES)) u_props (.clock_i(clock_i), .nrst_i(nrst_i),
  .ctrl_wr_i(ctrl_wr_i), .data_wr_i(data_wr_i), .wdata_i(wdata_i), .irq_enable_i(irq_enable_i),
  .serial_receive_pin_i(serial_receive_pin_i), .serial_port_control_o(serial_port_control_o),
  .serial_data_buffer_o(serial_data_buffer_o), .serial_transmit_pin_o(serial_transmit_pin_o), .irq_o(irq_o));

// ==== tb/usc_node.sv ====
// Remote serial node: sends frames to the device and samples its transmit line.
// Assumes a line idling high and bit times of BIT_CYCLES clocks.
`timescale 1ns/10ps
module usc_node #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic clock_i, // Clock.
  input  wire logic line_i,  // Device transmit line.
  output logic      line_o   // Device receive line.
);
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] bits, input logic nine, input logic stop);
    logic [10:0] fr;
    int          n;
    fr = nine ? {stop, bits, 1'b0} : {1'b1, stop, bits[7:0], 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      line_o <= fr[i];
      repeat (BIT_CYCLES) @(posedge clock_i);
    end
    line_o <= 1'b1;
    repeat (2 * BIT_CYCLES) @(posedge clock_i);
  endtask
  // Samples ten bit times after the start bit, mid-bit.
  task automatic recv(output logic [9:0] got);
    @(negedge line_i);
    repeat (BIT_CYCLES / 2) @(posedge clock_i);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYCLES) @(posedge clock_i);
      got[i] = line_i;
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the serial port control block.
// Assumes the design and the node model compiled first; bit time is four clocks.
`timescale 1ns/10ps
module testbench;
  localparam int B = 4;
  logic       clock_i, nrst_i, ctrl_wr_i, data_wr_i, irq_enable_i, rx_line, tx_line, irq_o;
  logic [7:0] wdata_i, ctrl, rbuf;
  logic [9:0] got;
  int         error_cnt = 0, compares = 0, cyc = 0;
  usc_serial_port #(.BIT_CYCLES(B)) DUT (.clock_i(clock_i), .nrst_i(nrst_i), .ctrl_wr_i(ctrl_wr_i),
    .data_wr_i(data_wr_i), .wdata_i(wdata_i), .irq_enable_i(irq_enable_i), .serial_receive_pin_i(rx_line),
    .serial_port_control_o(ctrl), .serial_data_buffer_o(rbuf), .serial_transmit_pin_o(tx_line), .irq_o(irq_o));
  usc_node #(.BIT_CYCLES(B)) u_node (.clock_i(clock_i), .line_i(tx_line), .line_o(rx_line));
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic d, input logic [7:0] v);
    ctrl_wr_i <= !d;
    data_wr_i <= d;
    wdata_i   <= v;
    @(posedge clock_i);
    ctrl_wr_i <= 1'b0;
    data_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic close_out;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    nrst_i = 1'b0;
    ctrl_wr_i = 1'b0;
    data_wr_i = 1'b0;
    wdata_i = 8'h00;
    irq_enable_i = 1'b1;
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    chk(10'(ctrl), 10'h040);
    wr(1'b0, 8'h00);
    chk(10'(ctrl), 10'h040);
    fork
      wr(1'b1, 8'ha5);
      u_node.recv(got);
    join
    chk(got, 10'h3a5);
    chk(10'(ctrl), 10'h042);
    chk(10'(irq_o), 10'h001);
    repeat (40) @(posedge clock_i);
    chk(10'(ctrl), 10'h042);
    irq_enable_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk(10'(irq_o), 10'h000);
    irq_enable_i <= 1'b1;
    wr(1'b0, 8'h88);
    chk(10'(ctrl), 10'h0c8);
    fork
      begin
        wr(1'b1, 8'h3c);
        repeat (8) @(posedge clock_i);
        wr(1'b1, 8'hff);
      end
      u_node.recv(got);
    join
    chk(got, 10'h33c);
    chk(10'(ctrl), 10'h0ca);
    repeat (3 * B) @(posedge clock_i);
    chk(10'(tx_line), 10'h001);
    wr(1'b0, 8'h80);
    fork
      wr(1'b1, 8'h5a);
      u_node.recv(got);
    join
    chk(got, 10'h25a);
    chk(10'(ctrl), 10'h0c2);
    wr(1'b0, 8'h10);
    u_node.send(9'h05a, 1'b0, 1'b1);
    chk(10'(ctrl), 10'h055);
    chk(10'(rbuf), 10'h05a);
    chk(10'(irq_o), 10'h001);
    u_node.send(9'h011, 1'b0, 1'b1);
    chk(10'(rbuf), 10'h05a);
    chk(10'(ctrl), 10'h055);
    wr(1'b0, 8'h00);
    u_node.send(9'h077, 1'b0, 1'b1);
    chk(10'(ctrl), 10'h040);
    chk(10'(rbuf), 10'h05a);
    wr(1'b0, 8'h30);
    u_node.send(9'h044, 1'b0, 1'b0);
    chk(10'(ctrl), 10'h070);
    wr(1'b0, 8'hb0);
    u_node.send(9'h022, 1'b1, 1'b1);
    chk(10'(ctrl), 10'h0f0);
    chk(10'(rbuf), 10'h05a);
    u_node.send(9'h133, 1'b1, 1'b1);
    chk(10'(ctrl), 10'h0f5);
    chk(10'(rbuf), 10'h033);
    wr(1'b0, 8'h90);
    u_node.send(9'h0c3, 1'b1, 1'b0);
    chk(10'(ctrl), 10'h0d1);
    chk(10'(rbuf), 10'h0c3);
    close_out;
  end
endmodule
